/* core/uatx_line_ctrl.sv */
// Serial transmit line control: register port, 32-word transmit FIFO, frame serialiser.
// Assumes one 25 MHz clock, an asynchronous active-low reset and a master that never waits.
// Summary of operation
// [R1] Break waits for frame end, holds line low
// [R2] Software keeps break at least one frame
// [R3] Break never drains or discards queued characters
// [R4] Parity bit only when parity enabled
// [R5] Select 0 odd parity, 1 even parity
// [R6] One or two stop bits by select
// [R7] FIFO off means one-byte holding register
// [R8] Word length field gives five to eight bits
// [R9] Stick parity sends constant inverse of even select
// [R10] Disabling finishes the character in progress
// [R11] Start low, LSB first, parity, stop high
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, depth must be a power of two
module uatx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data,
	output logic [CW-1:0] o_count
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic push, pop;

	// Handshakes and pointer updates
	always_comb begin
		o_ready = cnt_q != CW'(DEPTH);
		o_valid = cnt_q != '0;
		push = i_valid && o_ready;
		pop = o_valid && i_ready;
		wp_d = push ? wp_q + PW'(1) : wp_q;
		rp_d = pop ? rp_q + PW'(1) : rp_q;
		cnt_d = cnt_q + CW'(push) - CW'(pop);
		o_data = mem[rp_q];
		o_count = cnt_q;
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge i_ref_clk) begin
		if (push)
			mem[wp_q] <= i_data;
	end
endmodule : uatx_fifo

////////////////////////////////////////////////////////////////////////////////
module uatx_line_ctrl #(
	parameter int DEPTH = 32,
	parameter int CPB = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [uatx_pkg::ADDR_W-1:0] i_addr,
	input wire logic [uatx_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [uatx_pkg::DATA_W-1:0] o_rdata,
	output logic o_txd,
	output logic o_tx_ready,
	output logic o_busy
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int DW = $clog2(CPB);

	uatx_pkg::uatx_cfg_s cfg_q, cfg_d;
	logic en_q, en_d, txe_q, txe_d;
	logic [uatx_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic rdy_q, busy_q;
	uatx_pkg::uatx_state_e st_q, st_d;
	logic [DW-1:0] div_q, div_d;
	logic [3:0] bit_q, bit_d;
	uatx_pkg::uatx_frame_s fr_q, fr_d;
	logic txd_q, txd_d;
	logic f_ready, f_valid, acc_ok, push, pop, tick;
	logic [7:0] f_data;
	logic [CW-1:0] f_count;

	// Transmit buffer
	uatx_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_valid(push),
		.o_ready(f_ready),
		.i_data(i_wdata[7:0]),
		.o_valid(f_valid),
		.i_ready(pop),
		.o_data(f_data),
		.o_count(f_count)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register port: decode, writes, read data one cycle later
	always_comb begin
		acc_ok = cfg_q.tx_fifo_on ? f_ready : (f_count == '0); // R7
		push = i_wr && (i_addr == uatx_pkg::OFF_DATA) && acc_ok;
		cfg_d = cfg_q;
		en_d = en_q;
		txe_d = txe_q;
		if (i_wr && i_addr == uatx_pkg::OFF_LCR)
			cfg_d = i_wdata[7:0];
		if (i_wr && i_addr == uatx_pkg::OFF_CTRL) begin
			en_d = i_wdata[uatx_pkg::CTRL_EN];
			txe_d = i_wdata[uatx_pkg::CTRL_TXE];
		end
		rdata_d = '0;
		if (i_rd) begin
			case (i_addr)
				uatx_pkg::OFF_LCR: rdata_d = {24'h000000, cfg_q};
				uatx_pkg::OFF_CTRL: begin
					rdata_d[uatx_pkg::CTRL_EN] = en_q;
					rdata_d[uatx_pkg::CTRL_TXE] = txe_q;
				end
				uatx_pkg::OFF_STAT: begin
					rdata_d[uatx_pkg::STAT_BUSY] = st_q != uatx_pkg::S_IDLE;
					rdata_d[uatx_pkg::STAT_EMPTY] = f_count == '0;
					rdata_d[uatx_pkg::STAT_FULL] = !acc_ok;
					rdata_d[uatx_pkg::STAT_BRK] = st_q == uatx_pkg::S_BRK;
					rdata_d[uatx_pkg::STAT_LVL +: CW] = f_count;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_q <= uatx_pkg::LCR_RESET;
			en_q <= uatx_pkg::CTRL_EN_RESET;
			txe_q <= uatx_pkg::CTRL_TXE_RESET;
			rdata_q <= '0;
			rdy_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			en_q <= en_d;
			txe_q <= txe_d;
			rdata_q <= rdata_d;
			rdy_q <= acc_ok;
			busy_q <= st_d != uatx_pkg::S_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame serialiser
	always_comb begin
		tick = div_q == DW'(CPB - 1);
		st_d = st_q;
		bit_d = bit_q;
		fr_d = fr_q;
		pop = 1'b0;
		div_d = (tick || st_q == uatx_pkg::S_IDLE || st_q == uatx_pkg::S_BRK) ? '0 : div_q + DW'(1);
		case (st_q)
			uatx_pkg::S_IDLE: begin
				if (cfg_q.send_break)
					st_d = uatx_pkg::S_BRK; // R1
				else if (f_valid && en_q && txe_q) begin
					pop = 1'b1; // R3
					st_d = uatx_pkg::S_START;
					fr_d.data = f_data;
					fr_d.nbits = uatx_pkg::WLEN_BASE + {2'b00, cfg_q.tx_word_length}; // R8
					fr_d.par_on = cfg_q.tx_parity_on; // R4
					fr_d.par_bit = uatx_pkg::uatx_parity(cfg_q, f_data); // R5 R9
					fr_d.two = cfg_q.tx_two_stop; // R6
				end
			end
			uatx_pkg::S_START: begin
				if (tick) begin
					st_d = uatx_pkg::S_DATA;
					bit_d = '0;
				end
			end
			uatx_pkg::S_DATA: begin
				if (tick) begin
					bit_d = bit_q + 4'h1;
					if (bit_q == fr_q.nbits - 4'h1) begin
						bit_d = '0;
						st_d = fr_q.par_on ? uatx_pkg::S_PAR : uatx_pkg::S_STOP; // R4
					end
				end
			end
			uatx_pkg::S_PAR: begin
				if (tick)
					st_d = uatx_pkg::S_STOP;
			end
			uatx_pkg::S_STOP: begin
				if (tick) begin
					bit_d = bit_q + 4'h1;
					if (bit_q == {3'b000, fr_q.two}) begin
						bit_d = '0;
						st_d = uatx_pkg::S_IDLE; // R6 R10
					end
				end
			end
			uatx_pkg::S_BRK: begin
				if (!cfg_q.send_break)
					st_d = uatx_pkg::S_IDLE;
			end
			default: st_d = uatx_pkg::S_IDLE;
		endcase
		// Line level follows the next state
		case (st_d)
			uatx_pkg::S_START: txd_d = 1'b0; // R11
			uatx_pkg::S_DATA: txd_d = fr_d.data[bit_d[2:0]]; // R11
			uatx_pkg::S_PAR: txd_d = fr_d.par_bit;
			uatx_pkg::S_BRK: txd_d = 1'b0; // R1
			default: txd_d = 1'b1; // R11
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= uatx_pkg::S_IDLE;
			div_q <= '0;
			bit_q <= '0;
			fr_q <= '0;
			txd_q <= 1'b1;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			bit_q <= bit_d;
			fr_q <= fr_d;
			txd_q <= txd_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_txd = txd_q;
	assign o_tx_ready = rdy_q;
	assign o_busy = busy_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	// Break entry, hold and line level
	a_break_line_low: assert property ((st_q == uatx_pkg::S_BRK) |-> !o_txd) // R1
		else $error("line not low during break");
	a_break_after_frame: assert property ((st_q != uatx_pkg::S_IDLE && st_q != uatx_pkg::S_BRK)
		|=> (st_q != uatx_pkg::S_BRK)) // R1
		else $error("break entered mid frame");
	a_break_hold: assert property ((st_q == uatx_pkg::S_BRK && cfg_q.send_break) |=> st_q == uatx_pkg::S_BRK) // R1
		else $error("break released while still requested");
	a_break_keeps_fifo: assert property ((st_q == uatx_pkg::S_BRK && !push) |=> $stable(f_count)) // R3
		else $error("fifo changed during break");
	// Frame format
	a_no_parity_skip: assert property ((st_q == uatx_pkg::S_DATA && !fr_q.par_on) |=> st_q != uatx_pkg::S_PAR) // R4
		else $error("parity sent while disabled");
	a_parity_sense: assert property ((st_q == uatx_pkg::S_IDLE && pop && !cfg_q.tx_stick_parity && cfg_q.tx_parity_on)
		|=> ((^uatx_pkg::uatx_mask(fr_q.data, cfg_q.tx_word_length)) ^ fr_q.par_bit) == ~cfg_q.tx_even_select) // R5
		else $error("parity sense wrong");
	a_stick_value: assert property ((st_q == uatx_pkg::S_IDLE && pop && cfg_q.tx_stick_parity)
		|=> fr_q.par_bit == ~cfg_q.tx_even_select) // R9
		else $error("stick parity value wrong");
	a_stop_count: assert property ((st_q == uatx_pkg::S_STOP && tick && st_d == uatx_pkg::S_IDLE)
		|-> bit_q == {3'b000, fr_q.two}) // R6
		else $error("stop bit count wrong");
	a_char_mode: assert property ((i_wr && i_addr == uatx_pkg::OFF_DATA && !cfg_q.tx_fifo_on && f_count != '0)
		|=> f_count <= $past(f_count)) // R7
		else $error("holding register overfilled");
	a_word_length: assert property ((st_q == uatx_pkg::S_DATA && tick && st_d != uatx_pkg::S_DATA)
		|-> bit_q == fr_q.nbits - 4'h1) // R8
		else $error("wrong number of data bits");
	a_disable_finish: assert property ((st_q == uatx_pkg::S_DATA && !en_q) |=> st_q != uatx_pkg::S_IDLE) // R10
		else $error("frame cut by disable");
	a_start_low: assert property ($rose(st_q == uatx_pkg::S_START) |-> !o_txd ##1 !o_txd) // R11
		else $error("start bit not low");
	a_idle_high: assert property ((st_q == uatx_pkg::S_IDLE) |-> o_txd) // R11
		else $error("idle line not high");
	// Enable gating and busy flag
	a_idle_wait: assert property ((st_q == uatx_pkg::S_IDLE && !cfg_q.send_break && !(en_q && txe_q))
		|=> st_q == uatx_pkg::S_IDLE) // R10
		else $error("frame started while disabled");
	a_busy_state: assert property (o_busy == (st_q != uatx_pkg::S_IDLE)) // R1
		else $error("busy flag does not follow state");

	c_break: cover property ((st_q == uatx_pkg::S_BRK) ##1 (st_q == uatx_pkg::S_IDLE));
	c_parity_frame: cover property ((st_q == uatx_pkg::S_PAR) ##1 (st_q == uatx_pkg::S_STOP));
	c_two_stop: cover property ((st_q == uatx_pkg::S_STOP && fr_q.two && tick && st_d == uatx_pkg::S_IDLE));
	c_fifo_full: cover property (cfg_q.tx_fifo_on && !f_ready);
	c_write_refused: cover property (i_wr && i_addr == uatx_pkg::OFF_DATA && !acc_ok);
endmodule : uatx_line_ctrl

/* core/uatx_pkg.sv */
// Package for the serial transmit line control block: register map, field layout, states, helpers.
// Assumes a single 25 MHz reference clock and a simple address/strobe register port.
package uatx_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_LCR = 8'h2C;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h30;

	// Reset values and bit positions
	localparam logic [7:0] LCR_RESET = 8'h00;
	localparam int CTRL_EN = 0;
	localparam int CTRL_TXE = 8;
	localparam logic CTRL_EN_RESET = 1'b0;
	localparam logic CTRL_TXE_RESET = 1'b1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_EMPTY = 1;
	localparam int STAT_FULL = 2;
	localparam int STAT_BRK = 3;
	localparam int STAT_LVL = 8;

	// Fewest data bits in a frame
	localparam logic [3:0] WLEN_BASE = 4'h5;

	// Line control fields, bit 7 down to bit 0
	typedef struct packed {
		logic tx_stick_parity;
		logic [1:0] tx_word_length;
		logic tx_fifo_on;
		logic tx_two_stop;
		logic tx_even_select;
		logic tx_parity_on;
		logic send_break;
	} uatx_cfg_s;

	// Frame format captured at the start bit
	typedef struct packed {
		logic [7:0] data;
		logic [3:0] nbits;
		logic par_on;
		logic par_bit;
		logic two;
	} uatx_frame_s;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_START = 6'h02,
		S_DATA = 6'h04,
		S_PAR = 6'h08,
		S_STOP = 6'h10,
		S_BRK = 6'h20
	} uatx_state_e;

	// Keeps only the bits that the word length sends
	function automatic logic [7:0] uatx_mask(input logic [7:0] d, input logic [1:0] wl);
		return d & (8'hFF >> (~wl));
	endfunction : uatx_mask

	// Parity bit for one character under the given format
	function automatic logic uatx_parity(input uatx_cfg_s c, input logic [7:0] d);
		if (c.tx_stick_parity)
			return ~c.tx_even_select;
		return (^uatx_mask(d, c.tx_word_length)) ^ ~c.tx_even_select;
	endfunction : uatx_parity

endpackage : uatx_pkg

/* verif/tb_top.sv */
// Self-checking bench for the serial transmit line control block.
// Assumes the receiver model in its own file and a short bit time.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
	localparam int CPB = 4;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h00000000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic o_txd, o_tx_ready, o_busy, rx_par, rx_stop, par_on, two;
	logic [7:0] rx_data;
	logic [3:0] nbits = 4'h8;
	// Format table: length, parity, select, stick, stops
	logic [7:0] fmt [7] = '{8'h00, 8'h22, 8'h46, 8'h6A, 8'hE6, 8'hA2, 8'h72};
	int rx_cnt, n_mismatch = 0, n_tests = 0, cyc = 0, n;

	uatx_line_ctrl #(.DEPTH(32), .CPB(CPB)) dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_txd(o_txd),
		.o_tx_ready(o_tx_ready), .o_busy(o_busy));
	uatx_rx_model #(.CPB(CPB)) rx_u (.i_ref_clk(i_ref_clk), .i_line(o_txd), .i_nbits(nbits), .i_par_on(par_on),
		.i_two(two), .o_data(rx_data), .o_par(rx_par), .o_stop_ok(rx_stop), .o_cnt(rx_cnt));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and cycle watchdog
	always #20 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	// Register port cycles, one idle cycle after each strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		`CHK(o_rdata, e)
		@(posedge i_ref_clk);
	endtask : rd

	// Bounded wait for the receiver to count frames
	task automatic wait_rx(input int t);
		for (int k = 0; k < 600 && rx_cnt < t; k++) @(posedge i_ref_clk);
		`CHK(rx_cnt, t)
	endtask : wait_rx

	// One frame in a given format, checked at the receiver
	task automatic frame(input logic [7:0] c, input logic [7:0] d);
		int n0;
		logic [7:0] m;
		n0 = rx_cnt;
		m = d & (8'hFF >> (2'd3 - c[6:5]));
		nbits = 4'h5 + {2'b00, c[6:5]};
		par_on = c[1];
		two = c[3];
		wr(uatx_pkg::OFF_LCR, {24'h000000, c});
		wr(uatx_pkg::OFF_DATA, {24'h000000, d});
		wait_rx(n0 + 1);
		`CHK(rx_data, m)
		if (c[1]) `CHK(rx_par, c[7] ? ~c[2] : ((^m) ^ ~c[2]))
		`CHK(rx_stop, 1'b1)
	endtask : frame

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		par_on = 1'b0;
		two = 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		@(negedge i_ref_clk);
		`CHK({o_txd, o_tx_ready, o_busy}, 3'b100)
		@(posedge i_ref_clk);
		rd(uatx_pkg::OFF_LCR, 32'h00000000);
		rd(uatx_pkg::OFF_CTRL, 32'h00000100);
		rd(uatx_pkg::OFF_STAT, 32'h00000002);
		rd(8'h04, 32'h00000000);
		`CHK(o_tx_ready, 1'b1)
		// Every field but break, so the line stays idle
		wr(uatx_pkg::OFF_LCR, 32'hFFFFFFFE);
		rd(uatx_pkg::OFF_LCR, 32'h000000FE);
		wr(uatx_pkg::OFF_CTRL, 32'h00000101);
		// Every word length, parity mode and stop count
		foreach (fmt[i]) frame(fmt[i], 8'h35 + 8'h1B * 8'(i));
		// Back-to-back frames with two stop bits
		par_on = 1'b0;
		two = 1'b1;
		wr(uatx_pkg::OFF_LCR, 32'h00000078);
		n = rx_cnt;
		wr(uatx_pkg::OFF_DATA, 32'h0000003C);
		wr(uatx_pkg::OFF_DATA, 32'h000000C3);
		wait_rx(n + 2);
		`CHK({rx_data, rx_stop}, 9'h187)
		// Break set mid-frame, queue kept through it
		two = 1'b0;
		n = rx_cnt;
		wr(uatx_pkg::OFF_LCR, 32'h00000070);
		wr(uatx_pkg::OFF_DATA, 32'h0000005A);
		wr(uatx_pkg::OFF_LCR, 32'h00000071);
		wait_rx(n + 1);
		`CHK(rx_data, 8'h5A)
		wait_rx(n + 2);
		`CHK({rx_data, rx_stop}, 9'h000)
		wr(uatx_pkg::OFF_DATA, 32'h00000011);
		wr(uatx_pkg::OFF_DATA, 32'h00000022);
		rd(uatx_pkg::OFF_STAT, 32'h00000209);
		repeat (40) @(posedge i_ref_clk);
		`CHK({o_txd, o_busy}, 2'b01)
		wr(uatx_pkg::OFF_LCR, 32'h00000070);
		wait_rx(n + 4);
		`CHK(rx_data, 8'h22)
		// Disable during a frame: it completes, the next waits
		n = rx_cnt;
		wr(uatx_pkg::OFF_DATA, 32'h00000096);
		wr(uatx_pkg::OFF_DATA, 32'h00000069);
		wr(uatx_pkg::OFF_CTRL, 32'h00000100);
		wait_rx(n + 1);
		`CHK(rx_data, 8'h96)
		repeat (60) @(posedge i_ref_clk);
		`CHK({o_busy, rx_cnt == n + 1}, 2'b01)
		wr(uatx_pkg::OFF_CTRL, 32'h00000101);
		wait_rx(n + 2);
		`CHK(rx_data, 8'h69)
		// Character mode holds one byte only, transmitter held off meanwhile
		n = rx_cnt;
		wr(uatx_pkg::OFF_CTRL, 32'h00000001);
		rd(uatx_pkg::OFF_CTRL, 32'h00000001);
		wr(uatx_pkg::OFF_LCR, 32'h00000060);
		wr(uatx_pkg::OFF_DATA, 32'h000000A1);
		wr(uatx_pkg::OFF_DATA, 32'h000000B2);
		rd(uatx_pkg::OFF_STAT, 32'h00000104);
		`CHK(o_tx_ready, 1'b0)
		wr(uatx_pkg::OFF_CTRL, 32'h00000101);
		wait_rx(n + 1);
		`CHK(rx_data, 8'hA1)
		repeat (80) @(posedge i_ref_clk);
		`CHK(rx_cnt, n + 1)
		print_verdict();
	end

endmodule : tb_top

/* verif/uatx_rx_model.sv */
// Remote serial receiver model that samples the transmit line in mid-bit.
// Assumes the bench supplies the frame format and the bit time in clocks.
`timescale 1ns/10ps
module uatx_rx_model #(
	parameter int CPB = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_line,
	input wire logic [3:0] i_nbits,
	input wire logic i_par_on,
	input wire logic i_two,
	output logic [7:0] o_data,
	output logic o_par,
	output logic o_stop_ok,
	output int o_cnt
);
	initial o_cnt = 0;
	////////////////////////////////////////////////////////////////////////////////
	// One frame per falling edge, then wait for the line to idle high again
	always begin
		@(negedge i_line);
		repeat (CPB / 2) @(posedge i_ref_clk);
		o_data = 8'h00;
		for (int i = 0; i < i_nbits; i++) begin
			repeat (CPB) @(posedge i_ref_clk);
			o_data[i] = i_line;
		end
		if (i_par_on) begin
			repeat (CPB) @(posedge i_ref_clk);
			o_par = i_line;
		end
		repeat (CPB) @(posedge i_ref_clk);
		o_stop_ok = i_line;
		if (i_two) begin
			repeat (CPB) @(posedge i_ref_clk);
			o_stop_ok = o_stop_ok & i_line;
		end
		o_cnt++;
		wait (i_line === 1'b1);
	end
endmodule : uatx_rx_model
